// >>> rtl/safe_out_diag.sv
`timescale 1ns/100ps
`include "safe_out_defines.svh"
module safe_out_diag #(
   parameter int N              = 8,
   parameter int INTERVAL_TICKS = `INTERVAL_TICKS,
   parameter int PULSE_TICKS    = `PULSE_TICKS,
   parameter int TICK_CYCLES    = `TICK_CYCLES
) (
   // Clock and reset.
   input  wire logic                    clock,
   input  wire logic                    rstn,
   // Avalon-MM slave.
   input  wire safe_out_pkg::avm_req_t  avm_req,
   output      safe_out_pkg::avm_rsp_t  avm_rsp,
   // Driver pins and read-back.
   output logic [N-1:0]                 drive_en,
   input  wire logic [N-1:0]            rb_drop,
   input  wire logic [N-1:0]            rb_full_drop,
   input  wire logic [N-1:0]            rb_level,
   input  wire logic [N-1:0]            overcurrent,
   input  wire logic [N*16-1:0]         current_ma,
   // Supply relay and indicator.
   output logic                         switched_output_supply,
   output logic                         led_red
);
   import safe_out_pkg::*;

   // ****************************************
   // Input synchronisation
   // ****************************************
   logic [N-1:0] drop_s, full_s, level_s, oc_s;

   sync2 #(.WIDTH(4*N)) u_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   ({rb_drop, rb_full_drop, rb_level, overcurrent}),
      .dout  ({drop_s, full_s, level_s, oc_s})
   );
   logic [N*16-1:0] cur_s;

   sync2 #(.WIDTH(N*16)) u_cur_sync (
      .clock (clock),
      .rstn  (rstn),
      .din   (current_ma),
      .dout  (cur_s)
   );

   logic tick;

   tick_div #(.DIV(TICK_CYCLES)) u_tick (
      .clock (clock),
      .rstn  (rstn),
      .tick  (tick)
   );

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]   cfg_q [N];
   logic [N-1:0] cmd_q;
   logic [N-1:0] mask_q;
   logic [N-1:0] open_q, open_d;
   logic [N-1:0] short_q, short_d;
   logic [N-1:0] kill_q, kill_d;
   logic         pulse_fault_q, pulse_fault_d;
   logic         latched_q;
   logic [15:0]  cur_q [N];

   wire       wr      = avm_req.write;
   wire       rd      = avm_req.read;
   wire [7:0] addr    = avm_req.address;
   wire       cfg_sel = (addr[7:5] == 3'b000) && (addr[4:2] < N);
   wire       cur_sel = (addr[7:5] == 3'b010) && (addr[4:2] < N);
   wire [2:0] idx     = addr[4:2];
   wire [N-1:0] clr_open  = (wr && addr == `REG_OPEN_FLAGS)  ? avm_req.writedata[N-1:0] : '0;
   wire [N-1:0] clr_short = (wr && addr == `REG_SHORT_FLAGS) ? avm_req.writedata[N-1:0] : '0;
   wire         clr_pulse = wr && addr == `REG_STATUS && avm_req.writedata[`ST_PULSE_FAULT];

   // ****************************************
   // Per-output modes
   // ****************************************
   logic [N-1:0] monitored, pwm_mode, guard_on, on_state;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         monitored[i] = cfg_q[i][`CFG_SAFETY] && cfg_q[i][`CFG_DIAG];
         pwm_mode[i]  = cfg_q[i][`CFG_PWM];
         guard_on[i]  = cfg_q[i][`CFG_GUARD] && !pwm_mode[i];
         on_state[i]  = cmd_q[i] && cfg_q[i][`CFG_DIGITAL_H] && !kill_q[i];
      end
   end

   // ****************************************
   // Pulse test sequencer
   // ****************************************
   pulse_state_t st_q, st_d;
   logic [31:0]  tcnt_q, tcnt_d;
   logic [N-1:0] tested_q, tested_d;
   logic [N-1:0] xfault;

   wire blank = (st_q == PT_PULSE) || (st_q == PT_CHECK);

   always_comb begin
      st_d     = st_q;
      tcnt_d   = tcnt_q;
      tested_d = tested_q;
      xfault   = '0;
      unique case (st_q)
         PT_IDLE: begin
            if (tick) tcnt_d = tcnt_q + 32'd1;
            if (tick && tcnt_q >= 32'(INTERVAL_TICKS - 1)) begin
               st_d     = PT_PULSE;
               tcnt_d   = '0;
               tested_d = on_state & monitored;
            end
         end
         PT_PULSE: begin
            if (tick) tcnt_d = tcnt_q + 32'd1;
            if (tick && tcnt_q >= 32'(PULSE_TICKS - 2)) st_d = PT_CHECK;
         end
         PT_CHECK: begin
            // A read-back still high while the driver is off means another source feeds the line.
            xfault = tested_q & level_s;
            st_d   = PT_IDLE;
            tcnt_d = '0;
         end
         default: st_d = PT_IDLE;
      endcase
   end

   // ****************************************
   // Fault detection
   // ****************************************
   logic [N-1:0] open_ev, short_ev, oc_ev;
   logic [N-1:0] en_prev_q;
   logic [7:0]   settle_q;
   // Read-back lags the driver by the synchronisers and the load's own settling, and means
   // nothing during blanking, so static checks wait a few ticks after any driver change.
   wire          en_change = (drive_en != en_prev_q);
   wire          settled   = (settle_q == 8'h00) && !en_change && !blank;
   wire [N-1:0]  static_ok = monitored & on_state & drive_en & ~pwm_mode & {N{settled}};
   always_comb begin
      for (int i = 0; i < N; i++) begin
         open_ev[i]  = static_ok[i] && !drop_s[i];
         short_ev[i] = static_ok[i] && full_s[i];
         oc_ev[i]    = guard_on[i] && oc_s[i] && on_state[i];
      end
      open_d        = (open_q & ~clr_open) | open_ev;
      short_d       = (short_q & ~clr_short) | short_ev | oc_ev;
      pulse_fault_d = (pulse_fault_q && !clr_pulse) || (|xfault);
      kill_d        = kill_q | open_ev | short_ev | oc_ev | xfault;
   end

   wire [N-1:0] open_vis  = open_q & ~mask_q;
   wire [N-1:0] short_vis = short_q & ~mask_q;
   wire group_fault  = (|open_vis) || (|short_vis) || pulse_fault_q;
   wire any_event    = (|open_ev) || (|short_ev) || (|oc_ev) || (|xfault);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         st_q          <= PT_IDLE;
         tcnt_q        <= '0;
         tested_q      <= '0;
         open_q        <= '0;
         short_q       <= '0;
         pulse_fault_q <= 1'b0;
         kill_q        <= '0;
         latched_q     <= 1'b0;
         en_prev_q     <= '0;
         settle_q      <= 8'(`SETTLE_TICKS);
      end else begin
         st_q          <= st_d;
         tcnt_q        <= tcnt_d;
         tested_q      <= tested_d;
         open_q        <= open_d;
         short_q       <= short_d;
         pulse_fault_q <= pulse_fault_d;
         kill_q        <= kill_d;
         // Only reset, standing in for a power cycle, releases this latch.
         latched_q     <= latched_q || any_event;
         en_prev_q     <= drive_en;
         if (en_change) settle_q <= 8'(`SETTLE_TICKS);
         else if (tick && settle_q != 8'h00) settle_q <= settle_q - 8'h01;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rstn) begin
         drive_en               <= '0;
         switched_output_supply <= 1'b0;
         led_red                <= 1'b0;
      end else begin
         drive_en               <= on_state & ~(blank ? tested_q : '0);
         switched_output_supply <= !latched_q && !any_event;
         led_red                <= latched_q || any_event;
      end
   end

   // Current readback clamps small values to zero.
   always_ff @(posedge clock) begin
      for (int i = 0; i < N; i++) begin
         if (!rstn) begin
            cur_q[i] <= '0;
         end else begin
            cur_q[i] <= (cur_s[i*16 +: 16] >= `CURRENT_MIN_MA) ? cur_s[i*16 +: 16] : 16'h0000;
         end
      end
   end

   // ****************************************
   // Bus slave
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rstn) begin
         for (int i = 0; i < N; i++) cfg_q[i] <= `CFG_RESET;
         cmd_q  <= '0;
         mask_q <= '0;
      end else if (wr) begin
         if (cfg_sel) cfg_q[idx] <= avm_req.writedata[7:0];
         if (addr == `REG_OUT_CMD) cmd_q <= avm_req.writedata[N-1:0];
         if (addr == `REG_MASK) mask_q <= avm_req.writedata[N-1:0];
      end
   end

   wire [5:0] status = {blank, latched_q, !latched_q, latched_q, group_fault, pulse_fault_q};
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      if (cfg_sel)                        rdata = {24'h000000, cfg_q[idx]};
      else if (cur_sel)                   rdata = {16'h0000, cur_q[idx]};
      else if (addr == `REG_OUT_CMD)      rdata = 32'(cmd_q);
      else if (addr == `REG_OPEN_FLAGS)   rdata = 32'(open_vis);
      else if (addr == `REG_SHORT_FLAGS)  rdata = 32'(short_vis);
      else if (addr == `REG_MASK)         rdata = 32'(mask_q);
      else if (addr == `REG_STATUS)       rdata = 32'(status);
   end

   logic [31:0] rdata_q;
   logic        rd_ack_q;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdata_q  <= '0;
         rd_ack_q <= 1'b0;
      end else begin
         rd_ack_q <= rd && !rd_ack_q;
         if (rd && !rd_ack_q) rdata_q <= rdata;
      end
   end

   assign avm_rsp.waitrequest = rd && !rd_ack_q;
   assign avm_rsp.readdata    = rdata_q;
endmodule : safe_out_diag

// >>> pkg/safe_out_defines.svh
`ifndef SAFE_OUT_DEFINES_SVH
`define SAFE_OUT_DEFINES_SVH

// Register byte addresses.
`define REG_CONFIG_BASE  8'h00
`define REG_OUT_CMD      8'h20
`define REG_OPEN_FLAGS   8'h24
`define REG_SHORT_FLAGS  8'h28
`define REG_MASK         8'h2C
`define REG_STATUS       8'h30
`define REG_CURRENT_BASE 8'h40

// Configuration byte fields.
`define CFG_DIGITAL_H    0
`define CFG_SAFETY       1
`define CFG_CURRENT      2
`define CFG_PWM          3
`define CFG_DIAG         6
`define CFG_GUARD        7
`define CFG_RESET        8'h81

// Status fields.
`define ST_PULSE_FAULT   0
`define ST_GROUP_FAULT   1
`define ST_GLOBAL_FAULT  2
`define ST_SUPPLY_ON     3
`define ST_LED_RED       4
`define ST_TEST_BUSY     5

// Timing.
`define CLOCK_MHZ        100
`define TICK_US          1
`define PULSE_US         200
`define INTERVAL_S       30
`define TICK_CYCLES      (`TICK_US * `CLOCK_MHZ)
`define PULSE_TICKS      (`PULSE_US / `TICK_US)
`define INTERVAL_TICKS   (`INTERVAL_S * 1000000 / `TICK_US)
`define SETTLE_TICKS     20
`define CURRENT_MIN_MA   16'd100
`endif

// >>> pkg/safe_out_pkg.sv
package safe_out_pkg;
   typedef struct packed {
      logic [7:0] address;
      logic       read;
      logic       write;
      logic [31:0] writedata;
   } avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } avm_rsp_t;

   typedef enum logic [1:0] {
      PT_IDLE  = 2'b00,
      PT_PULSE = 2'b01,
      PT_CHECK = 2'b10
   } pulse_state_t;
endpackage : safe_out_pkg

// >>> rtl/sync2.sv
`timescale 1ns/100ps
module sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             rstn,
   // Data.
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : sync2

// >>> rtl/tick_div.sv
`timescale 1ns/100ps
module tick_div #(
   parameter int DIV = 100
) (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic rstn,
   // Enable pulse.
   output logic      tick
);
   localparam int W = $clog2(DIV + 1);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_q == W'(DIV - 1));
         cnt_q <= (cnt_q == W'(DIV - 1)) ? '0 : cnt_q + 1'b1;
      end
   end
endmodule : tick_div

// >>> dv/safe_out_diag_asserts.sv
`timescale 1ns/100ps
module safe_out_diag_checker #(
   parameter int N = 8
) (
   // Clock and reset.
   input wire logic                   clock,
   input wire logic                   rstn,
   // Bus and pins.
   input wire safe_out_pkg::avm_req_t avm_req,
   input wire safe_out_pkg::avm_rsp_t avm_rsp,
   input wire logic [N-1:0]           drive_en,
   input wire logic                   switched_output_supply,
   input wire logic                   led_red
);
   import safe_out_pkg::*;
   // ****************************************
   // Helper: a config write arming monitoring.
   // ****************************************
   logic armed_q;
   wire  arm_w = avm_req.write & ~avm_rsp.waitrequest & (avm_req.address[7:5] == 3'h0)
                 & avm_req.writedata[1] & avm_req.writedata[6];
   always_ff @(posedge clock) armed_q <= rstn & (armed_q | arm_w);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_rd;
      avm_rsp.waitrequest ##1 !avm_rsp.waitrequest;
   endsequence
   sequence s_up;
      !switched_output_supply ##1 switched_output_supply;
   endsequence
   property p_read_wait; $rose(avm_req.read) |-> s_rd; endproperty
   property p_write_nowait; avm_req.write |-> !avm_rsp.waitrequest; endproperty
   property p_restart; $rose(rstn) |-> s_up; endproperty
   property p_reset_quiet; $rose(rstn) |-> drive_en == '0 && !led_red; endproperty
   property p_red_off; led_red |-> !switched_output_supply; endproperty
   property p_red_hold; led_red |=> led_red; endproperty
   property p_supply_drop; $fell(switched_output_supply) |-> ##[0:2] led_red; endproperty
   property p_armed; $rose(led_red) |-> armed_q; endproperty
   a_read_wait: assert property (p_read_wait) else $error("read handshake wrong");
   a_write_nowait: assert property (p_write_nowait) else $error("write waited");
   a_restart: assert property (p_restart) else $error("supply not back");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live at restart");
   a_red_off: assert property (p_red_off) else $error("supply on while red");
   a_red_hold: assert property (p_red_hold) else $error("red cleared");
   a_supply_drop: assert property (p_supply_drop) else $error("supply dropped silently");
   a_armed: assert property (p_armed) else $error("fault while unmonitored");
endmodule : safe_out_diag_checker
bind safe_out_diag safe_out_diag_checker #(.N(N)) checker_i (.clock(clock), .rstn(rstn), .avm_req(avm_req),
   .avm_rsp(avm_rsp), .drive_en(drive_en), .switched_output_supply(switched_output_supply), .led_red(led_red));

// >>> dv/load_bank.sv
`timescale 1ns/100ps
module load_bank #(
   parameter int N = 8
) (
   // Driver side; fault per output: 0 good, 1 open, 2 short, 3 cross.
   input wire logic [N-1:0]   drive_en,
   input wire logic           supply,
   input wire logic [2*N-1:0] fault,
   // Read-back.
   output logic [N-1:0]       rb_drop,
   output logic [N-1:0]       rb_full_drop,
   output logic [N-1:0]       rb_level,
   output logic [N-1:0]       overcurrent
);
   always_comb begin
      for (int i = 0; i < N; i++) begin
         rb_drop[i] = drive_en[i] & supply & (fault[2*i+:2] != 2'h1);
         rb_full_drop[i] = drive_en[i] & supply & (fault[2*i+:2] == 2'h2);
         overcurrent[i] = rb_full_drop[i];
         rb_level[i] = (drive_en[i] & supply) | (fault[2*i+:2] == 2'h3);
      end
   end
endmodule : load_bank

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
   import safe_out_pkg::*;
   localparam int TC = 2;
   localparam int PT = 4;
   logic clock = 0, rstn = 0, sup, red;
   avm_req_t req = '0;
   avm_rsp_t rsp;
   logic [7:0] den, rbd, rbf, rbl, oc;
   logic [15:0] fault = '0;
   logic [127:0] cur = '0;
   logic [31:0] rdv;
   int fail_count = 0, num_checks = 0, n, m, cfg_m[8];
   always #5 clock = ~clock;
   safe_out_diag #(.N(8), .INTERVAL_TICKS(50), .PULSE_TICKS(PT), .TICK_CYCLES(TC)) safe_out_diag_i (
      .clock(clock), .rstn(rstn), .avm_req(req), .avm_rsp(rsp), .drive_en(den), .rb_drop(rbd),
      .rb_full_drop(rbf), .rb_level(rbl), .overcurrent(oc), .current_ma(cur),
      .switched_output_supply(sup), .led_red(red));
   load_bank #(.N(8)) load_bank_i (.drive_en(den), .supply(sup), .fault(fault), .rb_drop(rbd),
      .rb_full_drop(rbf), .rb_level(rbl), .overcurrent(oc));
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // The request is held until waitrequest is seen low, then released.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      req.address <= a;
      req.write <= w;
      req.read <= ~w;
      req.writedata <= d;
      k = 0;
      do begin @(posedge clock); k++; end while (rsp.waitrequest !== 1'b0 && k < 20);
      if (rsp.waitrequest !== 1'b0) chk(0, 1);
      rdv = rsp.readdata;
      req.read <= 0;
      req.write <= 0;
   endtask : bus
   task rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
      bus(0, a, 0);
      chk(rdv & msk, e);
   endtask : rd
   task do_reset;
      @(posedge clock);
      rstn <= 0;
      fault <= '0;
      repeat (8) @(posedge clock);
      rstn <= 1;
      repeat (3) @(posedge clock);
   endtask : do_reset
   task wait_red;
      for (n = 0; red !== 1'b1 && n < 500; n++) @(negedge clock);
      chk(red, 1);
   endtask : wait_red
   initial begin
      void'($urandom(54));
      do_reset;
      for (int i = 0; i < 8; i++) rd(8'(4*i), 32'hFF, 32'h81);
      rd(8'h30, 32'h1F, 32'h08);
      rd(8'h34, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 8; i++) begin
         cfg_m[i] = $urandom_range(0, 255) & 8'hBD;
         bus(1, 8'(4*i), 32'(cfg_m[i]));
      end
      for (int i = 0; i < 8; i++) rd(8'(4*i), 32'hFF, 32'(cfg_m[i]));
      @(posedge clock) cur <= {16'h1004, 16'($urandom_range(0, 4100)), 16'h0065, 16'h0064, 16'h0063,
                               16'h0001, 16'h0000, 16'h0096};
      repeat (4) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
         m = cur[16*i+:16];
         rd(8'h40 + 8'(4*i), 32'hFFFF, 32'((m >= 100) ? m : 0));
      end
      $display("register test done");
      do_reset;
      bus(1, 8'h00, 32'hC3);
      bus(1, 8'h0C, 32'h81);
      @(posedge clock) fault <= 16'h0041;
      bus(1, 8'h20, 32'h08);
      repeat (60) @(negedge clock);
      chk(red, 0);
      bus(1, 8'h20, 32'h09);
      wait_red;
      rd(8'h24, 32'hFF, 32'h01);
      rd(8'h28, 32'hFF, 32'h00);
      rd(8'h30, 32'h1F, 32'h16);
      chk(den[0], 0);
      bus(1, 8'h2C, 32'h01);
      rd(8'h24, 32'hFF, 32'h00);
      bus(1, 8'h2C, 32'h00);
      rd(8'h24, 32'hFF, 32'h01);
      bus(1, 8'h24, 32'h01);
      rd(8'h24, 32'hFF, 32'h00);
      chk(red, 1);
      $display("open load test done");
      do_reset;
      chk(sup, 1);
      bus(1, 8'h04, 32'hC3);
      @(posedge clock) fault <= 16'h0008;
      bus(1, 8'h20, 32'h02);
      wait_red;
      rd(8'h28, 32'hFF, 32'h02);
      rd(8'h24, 32'hFF, 32'h00);
      rd(8'h30, 32'h1F, 32'h16);
      $display("short test done");
      do_reset;
      bus(1, 8'h08, 32'hC3);
      bus(1, 8'h20, 32'h04);
      for (n = 0; den[2] !== 1'b1 && n < 50; n++) @(negedge clock);
      for (n = 0; den[2] !== 1'b0 && n < 300; n++) @(negedge clock);
      for (m = 0; den[2] !== 1'b1 && m < 50; m++) @(negedge clock);
      chk(m >= PT*TC-1 && m <= PT*TC+1, 1);
      for (m = 0; den[2] !== 1'b0 && m < 300; m++) @(negedge clock);
      chk(m >= 50*TC-PT*TC-2 && m <= 50*TC+2, 1);
      @(posedge clock) fault <= 16'h0030;
      wait_red;
      rd(8'h30, 32'h1F, 32'h17);
      $display("pulse test done");
      report_and_stop;
   end
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
endmodule : tb
